// ---- src/gpw_ports.sv ----
`include "gpw_params.svh"

// Operation
// [RULE1] Five ports are read and written by software through data memory, every pin in or out.
// [RULE2] A data read returns the live input level, not a latched copy, at the read.
// [RULE3] A data write loads the output latch, which holds until the next write.
// [RULE4] Port E has only bits 2..0; missing bits read as zero.
// [RULE5] Each digital input pin can take a weak pull-high chosen by its enable bit.
// [RULE6] Pull-high acts only for a digital input or NMOS output function, else stays off.
// [RULE7] Pull-high enable bit 0 disables, 1 enables, and all are zero after power-on.
// [RULE8] A falling edge on an enabled port A pin wakes the core from SLEEP or IDLE.
// [RULE9] Wake-up counts only for a GPIO input pin while the core is in IDLE or SLEEP.
// [RULE10] Wake enable bits 7..0 map to port A pins 7..0, 1 enables, zero after power-on.
// [RULE11] Reset sets data and direction to ones and pull-high to zero; low-power timeout keeps them.
// [RULE12] Direction 1 makes a pin an input, 0 a CMOS output driven from the latch.
// [RULE13] Reading an output pin returns the latch value, not the pin level.
// [RULE14] Pins pass a two-stage synchroniser before sampling or edge detection.
// [RULE15] Wake request is the OR of enabled falls, held until the core acknowledges.
module gpw_ports (
    input  logic                      clk,             // System clock, 25 MHz
    input  logic                      reset_n,         // Synchronous reset, active low
    input  logic [7:0]                mem_addr,        // Data memory address
    input  logic                      mem_wr,          // Write strobe
    input  logic                      mem_rd,          // Read strobe
    input  logic [7:0]                mem_wdata,       // Write data
    output logic [7:0]                mem_rdata,       // Read data, next cycle
    output logic                      mem_hit,         // Address maps here
    input  logic [`GPW_PIN_COUNT-1:0] pin_in,          // Pin levels, async
    output logic [`GPW_PIN_COUNT-1:0] pin_out,         // Output latch to pads
    output logic [`GPW_PIN_COUNT-1:0] pin_oe_n,        // Low while driving
    output logic [`GPW_PIN_COUNT-1:0] pin_pullup,      // Weak pull-high on
    input  logic [`GPW_PIN_COUNT-1:0] pin_gpio_sel,    // Pin function is GPIO
    input  logic [`GPW_PIN_COUNT-1:0] pin_nmos_sel,    // Pin function is NMOS out
    input  logic                      core_low_power,  // Core in IDLE or SLEEP
    input  logic                      wake_ack,        // Core left low power
    output logic                      wake_req         // Wake the core
);

    localparam gpw_pkg::gpw_state_s ST_RST = '{
        data:     {`GPW_PE_MASK & `GPW_DATA_RST, {4{`GPW_DATA_RST}}},
        dir:      {`GPW_PE_MASK & `GPW_DIR_RST, {4{`GPW_DIR_RST}}},
        pu:       {5{`GPW_PU_RST}},
        wake_en:  `GPW_WAKE_RST,
        pa_prev:  `GPW_PIN_IDLE,
        wake_req: 1'b0,
        rdata:    8'h00
    };

    gpw_pkg::gpw_state_s  st_ff;
    gpw_pkg::gpw_state_s  nxt_st;
    gpw_pkg::gpw_dec_s    dec;
    logic [`GPW_PIN_COUNT-1:0] pin_sync;
    logic [4:0][7:0]      pin_grp;
    logic [7:0]           rd_value;
    logic [7:0]           wake_fall;
    logic [7:0]           wake_hit;

    // Implemented bits of one port
    function automatic logic [7:0] port_mask(input logic [2:0] port);
        logic [7:0] m;
        m = `GPW_FULL_MASK;
        // [RULE4] Port E narrow
        if (port == `GPW_PORT_E) begin
            m = `GPW_PE_MASK;
        end
        return m;
    endfunction

    // Address decode; unmapped addresses give no hit
    function automatic gpw_pkg::gpw_dec_s decode(input logic [7:0] addr);
        gpw_pkg::gpw_dec_s d;
        d.hit  = 1'b1;
        d.port = addr[`GPW_PORT_MSB:`GPW_PORT_LSB];
        d.kind = gpw_pkg::GPW_KIND_DATA;
        // [RULE1] Five mapped ports
        case (addr)
            `GPW_ADDR_PA_DATA,
            `GPW_ADDR_PB_DATA,
            `GPW_ADDR_PC_DATA,
            `GPW_ADDR_PD_DATA,
            `GPW_ADDR_PE_DATA: begin
                d.kind = gpw_pkg::GPW_KIND_DATA;
            end
            `GPW_ADDR_PA_DIR,
            `GPW_ADDR_PB_DIR,
            `GPW_ADDR_PC_DIR,
            `GPW_ADDR_PD_DIR,
            `GPW_ADDR_PE_DIR: begin
                d.kind = gpw_pkg::GPW_KIND_DIR;
            end
            `GPW_ADDR_PA_PU,
            `GPW_ADDR_PB_PU,
            `GPW_ADDR_PC_PU,
            `GPW_ADDR_PD_PU,
            `GPW_ADDR_PE_PU: begin
                d.kind = gpw_pkg::GPW_KIND_PU;
            end
            `GPW_ADDR_PA_WAKE: begin
                d.kind = gpw_pkg::GPW_KIND_WAKE;
            end
            default: begin
                d.hit = 1'b0;
            end
        endcase
        return d;
    endfunction

    assign dec = decode(mem_addr);
    assign mem_hit = dec.hit;

    // [RULE14] Pin synchroniser
    gpw_sync u_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    // Port E has no pins above bit 2
    assign pin_grp[4][7:3] = 5'h00;

    // Per-pin drive, direction and pull-high
    for (genvar p = 0; p < `GPW_PIN_COUNT; p++) begin : g_pin
        assign pin_grp[p / 8][p % 8] = pin_sync[p];
        // [RULE12] Latch drives outputs
        assign pin_out[p] = st_ff.data[p / 8][p % 8];
        assign pin_oe_n[p] = st_ff.dir[p / 8][p % 8];
        // [RULE5] [RULE6] Gated pull-high
        assign pin_pullup[p] = st_ff.pu[p / 8][p % 8]
                             & ((st_ff.dir[p / 8][p % 8] & pin_gpio_sel[p])
                                | pin_nmos_sel[p]);
    end

    // Read mux; reserved bits masked to zero
    always_comb begin
        rd_value = 8'h00;
        if (dec.hit) begin
            unique case (dec.kind)
                gpw_pkg::GPW_KIND_DATA: begin
                    // [RULE2] [RULE13] Pin or latch
                    rd_value = (st_ff.dir[dec.port] & pin_grp[dec.port])
                             | (~st_ff.dir[dec.port] & st_ff.data[dec.port]);
                end
                gpw_pkg::GPW_KIND_DIR: begin
                    rd_value = st_ff.dir[dec.port];
                end
                gpw_pkg::GPW_KIND_PU: begin
                    rd_value = st_ff.pu[dec.port];
                end
                gpw_pkg::GPW_KIND_WAKE: begin
                    rd_value = st_ff.wake_en;
                end
            endcase
            // [RULE4] Unimplemented bits zero
            rd_value = rd_value & port_mask(dec.port);
        end
    end

    // Falling edges on port A, qualified for wake-up
    always_comb begin
        wake_fall = st_ff.pa_prev & ~pin_grp[0];
        // [RULE9] Only GPIO inputs in low power
        wake_hit  = wake_fall & st_ff.wake_en & st_ff.dir[0]
                  & pin_gpio_sel[7:0] & {8{core_low_power}};
    end

    // Next state: writes, read capture, wake request
    always_comb begin
        nxt_st = st_ff;
        if (mem_wr && dec.hit) begin
            unique case (dec.kind)
                gpw_pkg::GPW_KIND_DATA: begin
                    // [RULE3] Latch load
                    nxt_st.data[dec.port] = mem_wdata & port_mask(dec.port);
                end
                gpw_pkg::GPW_KIND_DIR: begin
                    // [RULE12] Direction write
                    nxt_st.dir[dec.port] = mem_wdata & port_mask(dec.port);
                end
                gpw_pkg::GPW_KIND_PU: begin
                    // [RULE7] Pull-high enables
                    nxt_st.pu[dec.port] = mem_wdata & port_mask(dec.port);
                end
                gpw_pkg::GPW_KIND_WAKE: begin
                    // [RULE10] Wake enables, bit per pin
                    nxt_st.wake_en = mem_wdata;
                end
            endcase
        end
        // Read data held until the next read strobe
        if (mem_rd) begin
            nxt_st.rdata = rd_value;
        end
        nxt_st.pa_prev = pin_grp[0];
        // [RULE8] [RULE15] Sticky request, new edge beats the ack
        nxt_st.wake_req = (|wake_hit) | (st_ff.wake_req & ~wake_ack);
    end

    // State register; a timeout in low power must not pulse reset_n
    always_ff @(posedge clk) begin
        // [RULE11] Reset values
        if (!reset_n) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign mem_rdata = st_ff.rdata;
    assign wake_req  = st_ff.wake_req;

    // Latch takes the written byte
    chk_latch_load: assert property ( // [RULE3]
        @(posedge clk) disable iff (!reset_n)
        (mem_wr && mem_addr == `GPW_ADDR_PA_DATA)
        |=> (pin_out[7:0] == $past(mem_wdata))
    ) else $error("port A latch did not load written data");

    // Latch holds without a write
    chk_latch_hold: assert property ( // [RULE3]
        @(posedge clk) disable iff (!reset_n)
        !(mem_wr && mem_addr == `GPW_ADDR_PB_DATA)
        |=> $stable(pin_out[15:8])
    ) else $error("port B latch changed without a write");

    // Port E upper bits read zero
    chk_pe_upper_zero: assert property ( // [RULE4]
        @(posedge clk) disable iff (!reset_n)
        (mem_rd && (mem_addr == `GPW_ADDR_PE_DIR
                    || mem_addr == `GPW_ADDR_PE_DATA))
        |=> (mem_rdata[7:3] == 5'h00)
    ) else $error("port E unimplemented bits read nonzero");

    // Cleared enables turn the pull-highs off
    chk_pullup_clear: assert property ( // [RULE7]
        @(posedge clk) disable iff (!reset_n)
        (mem_wr && mem_addr == `GPW_ADDR_PB_PU && mem_wdata == 8'h00)
        |=> (pin_pullup[15:8] == 8'h00)
    ) else $error("pull-high on after enables cleared");

    // Pull-high never on for a plain CMOS output
    chk_pullup_cmos: assert property ( // [RULE6]
        @(posedge clk) disable iff (!reset_n)
        (pin_oe_n[0] == 1'b0 && !pin_nmos_sel[0])
        |-> !pin_pullup[0]
    ) else $error("pull-high on for CMOS output pin");

    // Direction write sets output enables
    chk_dir_drive: assert property ( // [RULE12]
        @(posedge clk) disable iff (!reset_n)
        (mem_wr && mem_addr == `GPW_ADDR_PC_DIR)
        |=> (pin_oe_n[23:16] == $past(mem_wdata))
    ) else $error("port C direction write not applied");

    // Output pins read back the latch
    chk_read_latch: assert property ( // [RULE13]
        @(posedge clk) disable iff (!reset_n)
        (mem_rd && !mem_wr && mem_addr == `GPW_ADDR_PA_DATA
         && pin_oe_n[7:0] == 8'h00)
        |=> (mem_rdata == pin_out[7:0])
    ) else $error("output port read not from latch");

    // Input pins read the synchronised level
    chk_read_pin: assert property ( // [RULE2]
        @(posedge clk) disable iff (!reset_n)
        (mem_rd && mem_addr == `GPW_ADDR_PD_DATA && pin_oe_n[31:24] == 8'hff)
        |=> (mem_rdata == $past(pin_sync[31:24]))
    ) else $error("input port read not from pin level");

    // Synchroniser is two stages deep
    chk_sync_depth: assert property ( // [RULE14]
        @(posedge clk) disable iff (!reset_n)
        $fell(pin_sync[0]) |-> ($past(pin_in[0], 2) == 1'b0)
    ) else $error("pin level passed fewer than two stages");

    // Enabled fall in low power raises the request
    chk_wake_edge: assert property ( // [RULE8]
        @(posedge clk) disable iff (!reset_n)
        (st_ff.pa_prev[0] && !pin_sync[0] && st_ff.wake_en[0]
         && st_ff.dir[0][0] && pin_gpio_sel[0] && core_low_power)
        |=> wake_req
    ) else $error("enabled falling edge did not wake");

    // No new request outside low power
    chk_wake_awake: assert property ( // [RULE9]
        @(posedge clk) disable iff (!reset_n)
        (!core_low_power && !wake_req) |=> !wake_req
    ) else $error("wake request raised while awake");

    // Request holds until acknowledged
    chk_wake_hold: assert property ( // [RULE15]
        @(posedge clk) disable iff (!reset_n)
        (wake_req && !wake_ack) |=> wake_req
    ) else $error("wake request dropped before ack");

    // Reset leaves ports as inputs with latches high
    chk_reset_vals: assert property ( // [RULE11]
        @(posedge clk)
        $rose(reset_n)
        |-> (pin_oe_n == {`GPW_PIN_COUNT{1'b1}}
             && pin_out == {`GPW_PIN_COUNT{1'b1}}
             && pin_pullup == {`GPW_PIN_COUNT{1'b0}} && !wake_req)
    ) else $error("port reset values wrong");

    // Wake enables read back as written, even right after the write
    chk_wake_enable: assert property ( // [RULE10]
        @(posedge clk) disable iff (!reset_n)
        (mem_wr && mem_addr == `GPW_ADDR_PA_WAKE)
        ##1 (mem_rd && !mem_wr && mem_addr == `GPW_ADDR_PA_WAKE)
        |=> (mem_rdata == $past(mem_wdata, 2))
    ) else $error("wake enable did not read back");

    // Unmapped addresses read as zero
    chk_unmapped_read: assert property ( // [RULE1]
        @(posedge clk) disable iff (!reset_n)
        (mem_rd && !mem_hit) |=> (mem_rdata == 8'h00)
    ) else $error("unmapped address read nonzero");

    // Port E latch keeps only its three pins
    chk_pe_write_mask: assert property ( // [RULE4]
        @(posedge clk) disable iff (!reset_n)
        (mem_wr && mem_addr == `GPW_ADDR_PE_DATA)
        |=> (pin_out[34:32] == $past(mem_wdata[2:0]))
    ) else $error("port E latch did not load its bits");

    // Enabled GPIO input pin gets its pull-high
    chk_pullup_input: assert property ( // [RULE5]
        @(posedge clk) disable iff (!reset_n)
        (mem_wr && mem_addr == `GPW_ADDR_PB_PU && mem_wdata[0])
        ##1 (pin_oe_n[8] && pin_gpio_sel[8]) |-> pin_pullup[8]
    ) else $error("pull-high off for enabled input pin");

    // Acknowledge with no new edge drops the request
    chk_wake_release: assert property ( // [RULE15]
        @(posedge clk) disable iff (!reset_n)
        (wake_req && wake_ack && !(|wake_hit)) |=> !wake_req
    ) else $error("wake request kept after ack");

    // Read data stands until the next read strobe
    chk_rdata_hold: assert property ( // [RULE1]
        @(posedge clk) disable iff (!reset_n)
        !mem_rd |=> $stable(mem_rdata)
    ) else $error("read data changed without a read");

endmodule

// ---- src/gpw_params.svh ----
`ifndef GPW_PARAMS_SVH
`define GPW_PARAMS_SVH

// Pin and port geometry
`define GPW_PIN_COUNT 35
`define GPW_PORT_COUNT 5
`define GPW_PORT_A 3'h0
`define GPW_PORT_E 3'h4

// Implemented bit masks
`define GPW_FULL_MASK 8'hff
`define GPW_PE_MASK 8'h07

// Reset values
`define GPW_DATA_RST 8'hff
`define GPW_DIR_RST 8'hff
`define GPW_PU_RST 8'h00
`define GPW_WAKE_RST 8'h00
`define GPW_PIN_IDLE 8'hff

// Data memory addresses: port index in [4:2], register kind in [1:0]
`define GPW_PORT_MSB 4
`define GPW_PORT_LSB 2
`define GPW_ADDR_PA_DATA 8'h00
`define GPW_ADDR_PA_DIR 8'h01
`define GPW_ADDR_PA_PU 8'h02
`define GPW_ADDR_PA_WAKE 8'h03
`define GPW_ADDR_PB_DATA 8'h04
`define GPW_ADDR_PB_DIR 8'h05
`define GPW_ADDR_PB_PU 8'h06
`define GPW_ADDR_PC_DATA 8'h08
`define GPW_ADDR_PC_DIR 8'h09
`define GPW_ADDR_PC_PU 8'h0a
`define GPW_ADDR_PD_DATA 8'h0c
`define GPW_ADDR_PD_DIR 8'h0d
`define GPW_ADDR_PD_PU 8'h0e
`define GPW_ADDR_PE_DATA 8'h10
`define GPW_ADDR_PE_DIR 8'h11
`define GPW_ADDR_PE_PU 8'h12

`endif

// ---- src/gpw_pkg.sv ----
`include "gpw_params.svh"

package gpw_pkg;

    typedef logic [7:0] gpw_byte_t;

    // Register kind within a port
    typedef enum logic [1:0] {
        GPW_KIND_DATA,
        GPW_KIND_DIR,
        GPW_KIND_PU,
        GPW_KIND_WAKE
    } gpw_kind_e;

    // Address decode result
    typedef struct packed {
        logic      hit;
        logic [2:0] port;
        gpw_kind_e kind;
    } gpw_dec_s;

    // Whole state of the port block
    typedef struct packed {
        logic [4:0][7:0] data;
        logic [4:0][7:0] dir;
        logic [4:0][7:0] pu;
        gpw_byte_t       wake_en;
        gpw_byte_t       pa_prev;
        logic            wake_req;
        gpw_byte_t       rdata;
    } gpw_state_s;

    // Synchroniser state
    typedef struct packed {
        logic [`GPW_PIN_COUNT-1:0] meta;
        logic [`GPW_PIN_COUNT-1:0] stable;
    } gpw_sync_s;

endpackage

// ---- src/gpw_sync.sv ----
`include "gpw_params.svh"

module gpw_sync (
    input  logic                      clk,       // System clock
    input  logic                      reset_n,   // Synchronous reset, active low
    input  logic [`GPW_PIN_COUNT-1:0] async_in,  // Raw pin levels
    output logic [`GPW_PIN_COUNT-1:0] sync_out   // Levels in clk domain
);

    gpw_pkg::gpw_sync_s st_ff;
    gpw_pkg::gpw_sync_s nxt_st;

    // Two stages; the first is read only by the second
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.meta   = async_in;
        nxt_st.stable = st_ff.meta;
    end

    // Reset high so an idle pulled-up pin shows no false falling edge
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_ff <= '1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sync_out = st_ff.stable;

endmodule

// ---- bench/gpw_pins_model.sv ----
`include "gpw_params.svh"

// Far side of the pads: switches and loads on every pin
module gpw_pins_model (
    input  wire logic                      clk,        // System clock
    input  wire logic [`GPW_PIN_COUNT-1:0] pin_out,    // Latch from device
    input  wire logic [`GPW_PIN_COUNT-1:0] pin_oe_n,   // Low while device drives
    input  wire logic [`GPW_PIN_COUNT-1:0] pin_pullup, // Weak pull-high on
    input  wire logic [`GPW_PIN_COUNT-1:0] ext_val,    // Level of outside source
    input  wire logic [`GPW_PIN_COUNT-1:0] ext_en,     // Outside source attached
    output logic      [`GPW_PIN_COUNT-1:0] pin_in      // Resulting pad level
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [`GPW_PIN_COUNT-1:0] float_pat = '0;

    // Open pins wander every cycle so a stale level never passes
    always @(posedge clk) begin
        float_pat <= ~float_pat;
    end

    // Device drive wins, then source, then pull-high
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
                  | (pin_oe_n & ~ext_en & (pin_pullup | float_pat));
endmodule

// ---- bench/gpio_ports_pullup_wakeup_tb_top.sv ----
`include "gpw_params.svh"

module gpio_ports_pullup_wakeup_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NP = `GPW_PIN_COUNT;

    logic               clk = 1'b0;
    logic               reset_n = 1'b0;
    logic [7:0]         mem_addr = 8'h00;
    logic               mem_wr = 1'b0;
    logic               mem_rd = 1'b0;
    logic [7:0]         mem_wdata = 8'h00;
    logic [7:0]         mem_rdata;
    logic               mem_hit;
    logic [NP-1:0]      pin_in, pin_out, pin_oe_n, pin_pullup;
    logic [NP-1:0]      pin_gpio_sel = '1;
    logic [NP-1:0]      pin_nmos_sel = '0;
    logic [NP-1:0]      ext_val = '1;
    logic [NP-1:0]      ext_en = '1;
    logic               core_low_power = 1'b0;
    logic               wake_ack = 1'b0;
    logic               wake_req;
    logic               rd_d = 1'b0;
    logic [39:0]        shd, shr, shp, ext40, t;
    logic [63:0]        r;
    gpw_pkg::gpw_byte_t exp_q[$];
    gpw_pkg::gpw_byte_t e, raw;
    int                 miscompares = 0;
    int                 n_tests = 0;

    always #20 clk = ~clk;

    gpw_ports gpw_ports_i (.clk(clk), .reset_n(reset_n), .mem_addr(mem_addr),
        .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .mem_hit(mem_hit), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pullup(pin_pullup), .pin_gpio_sel(pin_gpio_sel), .pin_nmos_sel(pin_nmos_sel),
        .core_low_power(core_low_power), .wake_ack(wake_ack), .wake_req(wake_req));

    gpw_pins_model gpw_pins_model_i (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pullup(pin_pullup), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

    task automatic results();
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [NP-1:0] got, input logic [NP-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Read answer lands one edge after the strobe; oldest note pairs with it
    always @(posedge clk) begin
        rd_d <= mem_rd;
    end
    always @(negedge clk) begin
        if (rd_d) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : ~mem_rdata;
            n_tests++;
            if (mem_rdata !== e) begin
                miscompares++;
                $display("Error at %0t: got %h exp %h", $time, mem_rdata, e);
            end
        end
    end

    function automatic gpw_pkg::gpw_byte_t msk(input int k);
        return k == 4 ? `GPW_PE_MASK : `GPW_FULL_MASK;
    endfunction

    function automatic gpw_pkg::gpw_byte_t adr(input int k, input int kind);
        return 8'(k * 4 + kind);
    endfunction

    // Strobe held for one edge; caller ends a burst with idle
    task automatic op(input logic w, input gpw_pkg::gpw_byte_t a, d, exp);
        mem_addr = a;
        mem_wr = w;
        mem_rd = !w;
        mem_wdata = d;
        if (!w) exp_q.push_back(exp);
        @(negedge clk);
    endtask

    task automatic idle();
        mem_wr = 1'b0;
        mem_rd = 1'b0;
        @(negedge clk);
    endtask

    task automatic chk_reset();
        chk(pin_out, '1);
        chk(pin_oe_n, '1);
        chk(pin_pullup, '0);
        chk(NP'(wake_req), '0);
        for (int k = 0; k < 5; k++) begin
            op(1'b0, adr(k, 0), 8'h00, msk(k));
            op(1'b0, adr(k, 1), 8'h00, msk(k));
            op(1'b0, adr(k, 2), 8'h00, 8'h00);
        end
        op(1'b0, adr(0, 3), 8'h00, 8'h00);
        idle();
    endtask

    // Fall on port A with the given core mode and function, then expect wake or not
    task automatic wake_try(input gpw_pkg::gpw_byte_t drop, input logic lp, gs, exp);
        logic seen;
        core_low_power = lp;
        pin_gpio_sel[2] = gs;
        ext_val[7:0] = 8'hff;
        repeat (4) @(negedge clk);
        ext_val[7:0] = ~drop;
        seen = 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            if (wake_req === 1'b1) seen = 1'b1;
        end
        chk(NP'(seen), NP'(exp));
        if (exp) begin
            chk(NP'(wake_req), NP'(1));
            wake_ack = 1'b1;
            @(negedge clk);
            wake_ack = 1'b0;
            @(negedge clk);
            chk(NP'(wake_req), '0);
        end
    endtask

    initial begin
        void'($urandom(32'h63f4));
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        chk_reset();
        $display("test reset done");
        // Unmapped places refuse writes and read as zero
        op(1'b1, 8'h07, 8'h5a, 8'h00);
        chk(NP'(mem_hit), '0);
        op(1'b0, 8'h07, 8'h00, 8'h00);
        op(1'b0, 8'h13, 8'h00, 8'h00);
        op(1'b0, 8'hff, 8'h00, 8'h00);
        op(1'b0, 8'h03, 8'h00, 8'h00);
        chk(NP'(mem_hit), NP'(1));
        idle();
        $display("test unmapped done");
        for (int it = 0; it < 6; it++) begin
            r = {$urandom, $urandom};
            ext40 = r[39:0];
            ext_val = ext40[NP-1:0];
            r = {$urandom, $urandom};
            pin_gpio_sel = r[NP-1:0];
            r = {$urandom, $urandom};
            pin_nmos_sel = r[NP-1:0];
            shd = '0;
            shr = '0;
            shp = '0;
            for (int k = 0; k < 5; k++) begin
                raw = 8'($urandom);
                shd[8*k+:8] = raw & msk(k);
                op(1'b1, adr(k, 0), raw, 8'h00);
                raw = 8'($urandom);
                shr[8*k+:8] = raw & msk(k);
                op(1'b1, adr(k, 1), raw, 8'h00);
                raw = 8'($urandom);
                shp[8*k+:8] = raw & msk(k);
                op(1'b1, adr(k, 2), raw, 8'h00);
            end
            idle();
            chk(pin_out, shd[NP-1:0]);
            chk(pin_oe_n, shr[NP-1:0]);
            chk(pin_pullup, shp[NP-1:0] & ((shr[NP-1:0] & pin_gpio_sel) | pin_nmos_sel));
            t = (shd & ~shr) | (ext40 & shr);
            for (int k = 0; k < 5; k++) begin
                op(1'b0, adr(k, 0), 8'h00, t[8*k+:8] & msk(k));
                op(1'b0, adr(k, 1), 8'h00, shr[8*k+:8]);
                op(1'b0, adr(k, 2), 8'h00, shp[8*k+:8]);
            end
            idle();
            chk(pin_out, shd[NP-1:0]);
        end
        $display("test config done");
        // Input level reaches a read only through two stages
        pin_gpio_sel = '1;
        pin_nmos_sel = '0;
        // Released port B inputs must rest at the weak pull-high
        ext_en[15:8] = 8'h00;
        op(1'b1, adr(1, 1), 8'hff, 8'h00);
        op(1'b1, adr(1, 2), 8'hff, 8'h00);
        idle();
        repeat (3) @(negedge clk);
        chk(NP'(pin_pullup[15:8]), NP'(8'hff));
        op(1'b0, adr(1, 0), 8'h00, 8'hff);
        idle();
        ext_en[15:8] = 8'hff;
        $display("test pull-high done");
        op(1'b1, adr(0, 1), 8'hff, 8'h00);
        idle();
        ext_val[7:0] = 8'h3c;
        repeat (4) @(negedge clk);
        ext_val[7:0] = 8'hc3;
        op(1'b0, adr(0, 0), 8'h00, 8'h3c);
        op(1'b0, adr(0, 0), 8'h00, 8'h3c);
        op(1'b0, adr(0, 0), 8'h00, 8'hc3);
        idle();
        $display("test sync done");
        op(1'b1, adr(0, 3), 8'h04, 8'h00);
        op(1'b0, adr(0, 3), 8'h00, 8'h04);
        idle();
        wake_try(8'h04, 1'b1, 1'b1, 1'b1);
        wake_try(8'h08, 1'b1, 1'b1, 1'b0);
        wake_try(8'h04, 1'b0, 1'b1, 1'b0);
        wake_try(8'h04, 1'b1, 1'b0, 1'b0);
        $display("test wake done");
        pin_gpio_sel = '1;
        core_low_power = 1'b0;
        ext_val = '1;
        reset_n = 1'b0;
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        chk_reset();
        $display("test second reset done");
        repeat (2) @(negedge clk);
        results();
    end

    // Hang guard
    initial begin
        #2000000;
        miscompares++;
        results();
    end
endmodule
